// ### hw/fsp_pkg.sv
package fsp_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  // strobe low width 6.0 .. 6.8 us; aim mid range
  localparam int STB_WIDTH_NS = 6400;
  localparam int STB_CYC = STB_WIDTH_NS / CLK_PERIOD_NS;
  // pins valid 0 .. 1.5 us after the falling strobe edge
  localparam int VALID_DELAY_NS = 500;
  localparam int VALID_CYC = VALID_DELAY_NS / CLK_PERIOD_NS;
  // input sample 10.5 .. 12.5 us after new output data
  localparam int LATCH_DELAY_NS = 11500;
  localparam int LATCH_CYC = LATCH_DELAY_NS / CLK_PERIOD_NS;
  // parameter pins released 56.0 .. 64.5 us after strobe fall
  localparam int RELEASE_DELAY_NS = 60000;
  localparam int RELEASE_CYC = RELEASE_DELAY_NS / CLK_PERIOD_NS;
  // clock watchdog 100 .. 150 us
  localparam int WDOG_NS = 125000;
  localparam int WDOG_CYC = WDOG_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 16;

  // ----------------------------------------------------------------
  // values
  // ----------------------------------------------------------------
  localparam int NIB_W = 4;
  localparam logic [3:0] PORT_RESET_VAL = 4'hf;
  localparam logic [2:0] IO_CODE_RELEASE = 3'h7;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] out_n_oe;
    logic [3:0] strobe_oe_n;
  } fsp_unused_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] value;
  } fsp_nib_t;

endpackage

// ### hw/fsp_sync.sv
`timescale 1ns/1ps
// two flip-flop synchroniser for pin inputs
module fsp_sync #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_r <= '1;
      q <= '1;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // fsp_sync

// ### hw/fsp_port.sv
`timescale 1ns/1ps
// one open-drain nibble port with its update strobe
module fsp_port #(
  parameter int W = 4,
  parameter int STB = fsp_pkg::STB_CYC,
  parameter int VAL = fsp_pkg::VALID_CYC,
  parameter int LAT = fsp_pkg::LATCH_CYC,
  parameter int REL = fsp_pkg::RELEASE_CYC,
  parameter bit REL_EN = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr,
  input wire logic [W-1:0] wr_data,
  input wire logic release_mode,
  input wire logic [W-1:0] pin_in_s,
  output logic [W-1:0] pin_oe_n,
  output logic strobe_oe_n,
  output logic busy,
  output fsp_pkg::fsp_nib_t sample
);
  typedef enum logic [1:0] {S_IDLE, S_LOW, S_WAIT} fsp_pst_t;

  fsp_pst_t st_r;
  logic [fsp_pkg::CNT_W-1:0] cnt_r;
  logic [W-1:0] reg_r;
  logic drive_r;
  logic pend_r;
  logic [W-1:0] pend_val_r;
  logic boot_r;

  wire start = (st_r == S_IDLE) && (pend_r || boot_r);
  wire [W-1:0] start_val = boot_r ? fsp_pkg::PORT_RESET_VAL : pend_val_r;
  wire hit_val = cnt_r == fsp_pkg::CNT_W'(VAL);
  wire hit_lat = cnt_r == fsp_pkg::CNT_W'(VAL + LAT);
  wire hit_rel = cnt_r == fsp_pkg::CNT_W'(REL);
  wire end_low = cnt_r == fsp_pkg::CNT_W'(STB - 1);
  wire [fsp_pkg::CNT_W-1:0] last = fsp_pkg::CNT_W'(REL_EN ? REL : VAL + LAT);

  assign busy = (st_r != S_IDLE) || pend_r || boot_r;

  // ----------------------------------------------------------------
  // request queue of one: no retrigger while a pulse runs
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pend_r <= 1'b0;
      pend_val_r <= '1;
      boot_r <= 1'b1;
    end
    else
    begin
      if (wr)
      begin
        pend_r <= 1'b1;
        pend_val_r <= wr_data;
      end
      else if (start && !boot_r)
        pend_r <= 1'b0;
      if (start)
        boot_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // strobe, drive and sample sequence
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_r <= S_IDLE;
      cnt_r <= '0;
      reg_r <= fsp_pkg::PORT_RESET_VAL;
      drive_r <= 1'b0;
      strobe_oe_n <= 1'b1;
      pin_oe_n <= '1;
      sample <= '0;
    end
    else
    begin
      sample.valid <= 1'b0;
      unique case (st_r)
        S_IDLE:
          if (start)
          begin
            st_r <= S_LOW;
            cnt_r <= '0;
            reg_r <= start_val;
            drive_r <= !boot_r;
            strobe_oe_n <= 1'b0;
          end
        S_LOW, S_WAIT:
        begin
          cnt_r <= cnt_r + 1'b1;
          if (end_low)
          begin
            strobe_oe_n <= 1'b1;
            st_r <= S_WAIT;
          end
          if (hit_val && drive_r)
            pin_oe_n <= reg_r;
          if (hit_lat)
          begin
            sample.valid <= 1'b1;
            sample.value <= pin_in_s;
          end
          if (REL_EN && release_mode && hit_rel)
            pin_oe_n <= '1;
          if (cnt_r == last)
            st_r <= S_IDLE;
        end
      endcase
    end
  end
endmodule // fsp_port

// ### hw/fsp_top.sv
`timescale 1ns/1ps
// What this block does
// RULE1 - parameter pins drive and sample continuously by default; the code samples them once per strobe pulse, 11.5 us after new output data
// RULE2 - io code seven releases parameter pins after each parameter write
// RULE3 - parameter value kept in register, then sent to open-drain pins
// RULE4 - parameter inputs sampled 10.5 to 12.5 us after new output data
// RULE5 - each new parameter value announced by active-low strobe pulse
// RULE6 - parameter strobe stays low 6.0 to 6.8 us
// RULE7 - parameter outputs valid within 1.5 us after strobe falls
// RULE8 - io code seven: parameter pins released 56.0 to 64.5 us after strobe
// RULE9 - data exchange disabled after reset until first parameter output; the code enables it on the first parameter write request
// RULE10 - reset loads parameter register with all ones, drivers released
// RULE11 - reset also emits one normal parameter strobe
// RULE12 - data value stored in register, then driven on open-drain data pins
// RULE13 - data inputs sampled a fixed delay after new data output
// RULE14 - each new data value announced by active-low data strobe pulse
// RULE15 - reset loads data register with all ones, drivers released
// RULE16 - reset also emits one normal data strobe
// RULE17 - data strobe pin is also watched as a reset input
// RULE18 - transmitter and receiver never enabled together
// RULE19 - clock watchdog disables transmitter after 100 to 150 us stall
// RULE20 - data strobe low 6.0 to 6.8 us, inputs taken 10.5 to 12.5 us
// RULE21 - data outputs valid within 1.5 us after data strobe falls
// RULE22 - one strobe per update, never retriggered while a pulse is active
module fsp_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic parameter_write_request,
  input wire logic [3:0] param_value,
  input wire logic data_exchange_request,
  input wire logic [3:0] data_value,
  input wire logic [2:0] io_code,
  input wire logic [3:0] parameter_pins_in,
  input wire logic [3:0] data_pins_in,
  input wire logic data_update_pulse_n_in,
  input wire logic tx_request,
  input wire logic rx_request,
  input wire logic clk_alive,
  output logic [3:0] parameter_pins_oe_n,
  output logic [3:0] data_pins_oe_n,
  output logic param_update_pulse_n_oe_n,
  output logic data_update_pulse_n_oe_n,
  output logic param_sample_valid,
  output logic [3:0] param_sample,
  output logic data_sample_valid,
  output logic [3:0] data_sample,
  output logic data_exchange_enabled,
  output logic strobe_reset_req,
  output logic tx_enable,
  output logic rx_enable
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] par_in_s;
  logic [3:0] dat_in_s;
  logic [1:0] misc_s;

  fsp_sync #(.W(4)) u_sync_par (
    .clk(clk), .rst(rst), .d(parameter_pins_in), .q(par_in_s)
  );
  fsp_sync #(.W(4)) u_sync_dat (
    .clk(clk), .rst(rst), .d(data_pins_in), .q(dat_in_s)
  );
  fsp_sync #(.W(2)) u_sync_misc (
    .clk(clk), .rst(rst),
    .d({data_update_pulse_n_in, clk_alive}),
    .q(misc_s)
  );

  wire stb_pin_s = misc_s[1];
  wire alive_s = misc_s[0];

  // ----------------------------------------------------------------
  // parameter port
  // ----------------------------------------------------------------
  logic [3:0] par_oe_w;
  logic par_stb_w;
  fsp_pkg::fsp_nib_t par_smp;
  wire rel_mode = io_code == fsp_pkg::IO_CODE_RELEASE; // [RULE2]

  // [RULE1] [RULE3] [RULE4] [RULE5] [RULE6] [RULE7] [RULE8]
  // [RULE10] [RULE11] [RULE22]
  fsp_port #(.REL_EN(1'b1)) u_par (
    .clk(clk),
    .rst(rst),
    .wr(parameter_write_request),
    .wr_data(param_value),
    .release_mode(rel_mode),
    .pin_in_s(par_in_s),
    .pin_oe_n(par_oe_w),
    .strobe_oe_n(par_stb_w),
    .busy(),
    .sample(par_smp)
  );

  // ----------------------------------------------------------------
  // data port, gated until first parameter write request
  // ----------------------------------------------------------------
  logic [3:0] dat_oe_w;
  logic dat_stb_w;
  fsp_pkg::fsp_nib_t dat_smp;
  logic dx_en_r;
  wire dat_wr = data_exchange_request && dx_en_r; // [RULE9]

  // [RULE12] [RULE13] [RULE14] [RULE15] [RULE16] [RULE20] [RULE21]
  fsp_port #(.REL_EN(1'b0)) u_dat (
    .clk(clk),
    .rst(rst),
    .wr(dat_wr),
    .wr_data(data_value),
    .release_mode(1'b0),
    .pin_in_s(dat_in_s),
    .pin_oe_n(dat_oe_w),
    .strobe_oe_n(dat_stb_w),
    .busy(),
    .sample(dat_smp)
  );

  // ----------------------------------------------------------------
  // strobe pin as reset input, watchdog, line drivers
  // ----------------------------------------------------------------
  logic [fsp_pkg::CNT_W-1:0] wd_cnt_r;
  wire wd_trip = wd_cnt_r >= fsp_pkg::CNT_W'(fsp_pkg::WDOG_CYC);
  // own strobe level delayed to line up with the synchronised pin
  logic [1:0] stb_hist_r;
  // low seen on the pin while we are not pulling it means an outside reset
  wire ext_rst = !stb_pin_s && stb_hist_r[1]; // [RULE17]
  wire tx_nxt = tx_request && !wd_trip; // [RULE19]
  wire rx_nxt = rx_request && !tx_nxt; // [RULE18]

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dx_en_r <= 1'b0;
      wd_cnt_r <= '0;
      stb_hist_r <= 2'h3;
      parameter_pins_oe_n <= '1;
      data_pins_oe_n <= '1;
      param_update_pulse_n_oe_n <= 1'b1;
      data_update_pulse_n_oe_n <= 1'b1;
      param_sample_valid <= 1'b0;
      param_sample <= '0;
      data_sample_valid <= 1'b0;
      data_sample <= '0;
      data_exchange_enabled <= 1'b0;
      strobe_reset_req <= 1'b0;
      tx_enable <= 1'b0;
      rx_enable <= 1'b0;
    end
    else
    begin
      if (parameter_write_request)
        dx_en_r <= 1'b1; // [RULE9]
      if (alive_s)
        wd_cnt_r <= '0;
      else if (!wd_trip)
        wd_cnt_r <= wd_cnt_r + 1'b1;
      parameter_pins_oe_n <= par_oe_w;
      data_pins_oe_n <= dat_oe_w;
      param_update_pulse_n_oe_n <= par_stb_w;
      data_update_pulse_n_oe_n <= dat_stb_w;
      stb_hist_r <= {stb_hist_r[0], data_update_pulse_n_oe_n}; // [RULE17]
      param_sample_valid <= par_smp.valid;
      if (par_smp.valid)
        param_sample <= par_smp.value;
      data_sample_valid <= dat_smp.valid;
      if (dat_smp.valid)
        data_sample <= dat_smp.value;
      data_exchange_enabled <= dx_en_r;
      strobe_reset_req <= ext_rst;
      tx_enable <= tx_nxt;
      rx_enable <= rx_nxt;
    end
  end
endmodule // fsp_top

// ### dv/fsp_sva.sv
`timescale 1ns/1ps
module fsp_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] io_code,
  input wire logic clk_alive,
  input wire logic data_update_pulse_n_in,
  input wire logic [3:0] parameter_pins_oe_n,
  input wire logic [3:0] data_pins_oe_n,
  input wire logic param_update_pulse_n_oe_n,
  input wire logic data_update_pulse_n_oe_n,
  input wire logic param_sample_valid,
  input wire logic data_sample_valid,
  input wire logic data_exchange_enabled,
  input wire logic strobe_reset_req,
  input wire logic tx_enable,
  input wire logic rx_enable
);
  // ------------------------------------------------------------
  // cycles since strobe fall, cycles without clock
  // ------------------------------------------------------------
  logic pq_r, dq_r;
  logic [15:0] pc_r, dc_r, wc_r;
  always_ff @(posedge clk)
  begin
    pq_r <= param_update_pulse_n_oe_n;
    dq_r <= data_update_pulse_n_oe_n;
    if (rst) pc_r <= 16'hffff;
    else if (pq_r && !param_update_pulse_n_oe_n) pc_r <= 16'h0001;
    else if (pc_r != 16'hffff) pc_r <= pc_r + 16'h0001;
    if (rst) dc_r <= 16'hffff;
    else if (dq_r && !data_update_pulse_n_oe_n) dc_r <= 16'h0001;
    else if (dc_r != 16'hffff) dc_r <= dc_r + 16'h0001;
    if (rst || clk_alive) wc_r <= 16'h0000;
    else if (wc_r != 16'hffff) wc_r <= wc_r + 16'h0001;
  end
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_prise;
    $rose(param_update_pulse_n_oe_n);
  endsequence
  sequence s_drise;
    $rose(data_update_pulse_n_oe_n);
  endsequence
  a_pstb_width: assert property (
    s_prise |-> pc_r inside {[600:680]})
    else $error("param strobe width");
  a_dstb_width: assert property (
    s_drise |-> dc_r inside {[600:680]})
    else $error("data strobe width");
  a_ppin_time: assert property (
    $changed(parameter_pins_oe_n) |-> pc_r <= 150
    || (io_code == 3'h7 && pc_r inside {[5600:6450]}))
    else $error("param pins change time");
  a_dpin_time: assert property (
    $changed(data_pins_oe_n) |-> dc_r <= 150)
    else $error("data pins change time");
  a_psample_at: assert property (
    param_sample_valid |-> pc_r inside {[1050:1300]})
    else $error("param sample time");
  a_dsample_at: assert property (
    data_sample_valid |-> dc_r inside {[1050:1300]})
    else $error("data sample time");
  a_release_done: assert property (
    io_code == 3'h7 && pc_r == 6450 |-> &parameter_pins_oe_n)
    else $error("param pins not released");
  a_exch_off: assert property (
    $past(rst) |-> !data_exchange_enabled)
    else $error("exchange enabled at reset");
  a_txrx_excl: assert property (
    !(tx_enable && rx_enable))
    else $error("tx and rx both on");
  a_wdog_tx: assert property (
    wc_r >= 16'h3a98 |-> !tx_enable)
    else $error("tx on without clock");
  a_strobe_rst: assert property (
    (data_update_pulse_n_oe_n && !data_update_pulse_n_in) [*4]
    |-> ##[0:4] strobe_reset_req)
    else $error("strobe reset missed");
  a_srst_cause: assert property (
    strobe_reset_req |-> $past(data_update_pulse_n_oe_n, 3)
    && !$past(data_update_pulse_n_in, 3))
    else $error("strobe reset without outside low");
endmodule // fsp_sva
bind fsp_top fsp_sva i_fsp_sva (.*);

// ### dv/fsp_partner.sv
`timescale 1ns/1ps
module fsp_partner (
  input wire logic [3:0] p_oe_n,
  input wire logic [3:0] d_oe_n,
  input wire logic [3:0] p_ext,
  input wire logic [3:0] d_ext,
  input wire logic s_oe_n,
  input wire logic s_ext_n,
  output logic [3:0] p_pin,
  output logic [3:0] d_pin,
  output logic s_pin
);
  // pull-ups, wired-and with outside drivers
  assign p_pin = p_oe_n & p_ext;
  assign d_pin = d_oe_n & d_ext;
  assign s_pin = s_oe_n & s_ext_n;
endmodule // fsp_partner

// ### dv/field_slave_param_data_ports_bench.sv
`timescale 1ns/1ps
module field_slave_param_data_ports_bench;
  logic clk = 0, rst = 1, parameter_write_request = 0;
  logic data_exchange_request = 0, tx_request = 0, rx_request = 0;
  logic clk_alive = 1, ext_n = 1;
  logic [2:0] io_code = 3'h0;
  logic [3:0] param_value = 4'h0, data_value = 4'h0;
  logic [3:0] p_ext = 4'hf, d_ext = 4'hf;
  logic [3:0] parameter_pins_in, data_pins_in, parameter_pins_oe_n;
  logic [3:0] data_pins_oe_n, param_sample, data_sample;
  logic data_update_pulse_n_in, param_update_pulse_n_oe_n;
  logic data_update_pulse_n_oe_n, param_sample_valid, data_sample_valid;
  logic data_exchange_enabled, strobe_reset_req, tx_enable, rx_enable;
  int miscompares = 0, total_checks = 0, cyc = 0;
  always #5 clk = ~clk;
  fsp_top i_fsp_top (.*);
  fsp_partner i_fsp_partner (.p_oe_n(parameter_pins_oe_n),
    .d_oe_n(data_pins_oe_n), .p_ext(p_ext), .d_ext(d_ext),
    .s_oe_n(data_update_pulse_n_oe_n), .s_ext_n(ext_n),
    .p_pin(parameter_pins_in), .d_pin(data_pins_in),
    .s_pin(data_update_pulse_n_in));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(string n, logic [3:0] s, logic [3:0] e);
    total_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wt(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse(logic p, logic [3:0] v);
    @(negedge clk);
    param_value = v;
    data_value = v;
    if (p) parameter_write_request = 1;
    else data_exchange_request = 1;
    @(negedge clk);
    parameter_write_request = 0;
    data_exchange_request = 0;
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_boot;
    wt(300);
    chk("pstb", param_update_pulse_n_oe_n, 4'h0);
    chk("dstb", data_update_pulse_n_oe_n, 4'h0);
    chk("ppins", parameter_pins_oe_n, 4'hf);
    chk("dpins", data_pins_oe_n, 4'hf);
    chk("dexen", data_exchange_enabled, 4'h0);
    wt(6000);
    $display("test boot done");
  endtask
  task automatic t_refuse;
    pulse(0, 4'h0);
    wt(300);
    chk("dstb", data_update_pulse_n_oe_n, 4'h1);
    chk("dpins", data_pins_oe_n, 4'hf);
    $display("test refuse done");
  endtask
  task automatic t_param(logic [3:0] v, logic [3:0] e, logic rel);
    io_code = rel ? 3'h7 : 3'h0;
    p_ext = e;
    pulse(1, v);
    wt(300);
    chk("pstb", param_update_pulse_n_oe_n, 4'h0);
    chk("ppins", parameter_pins_oe_n, v);
    chk("dexen", data_exchange_enabled, 4'h1);
    wt(1000);
    chk("psmp", param_sample, v & e);
    wt(5300);
    chk("ppins", parameter_pins_oe_n, rel ? 4'hf : v);
    $display("test param done");
  endtask
  task automatic t_data(logic [3:0] v, logic [3:0] e);
    d_ext = e;
    pulse(0, v);
    pulse(0, ~v);
    wt(300);
    chk("dstb", data_update_pulse_n_oe_n, 4'h0);
    chk("dpins", data_pins_oe_n, v);
    wt(1000);
    chk("dsmp", data_sample, v & e);
    wt(300);
    chk("dpins", data_pins_oe_n, ~v);
    wt(1000);
    chk("dsmp", data_sample, ~v & e);
    $display("test data done");
  endtask
  task automatic t_srst;
    ext_n = 0;
    wt(20);
    chk("srst", strobe_reset_req, 4'h1);
    ext_n = 1;
    wt(20);
    chk("srst", strobe_reset_req, 4'h0);
    $display("test strobe reset done");
  endtask
  task automatic t_txrx;
    tx_request = 1;
    wt(10);
    chk("txrx", {tx_enable, rx_enable}, 4'h2);
    rx_request = 1;
    wt(10);
    chk("both", tx_enable & rx_enable, 4'h0);
    tx_request = 0;
    wt(10);
    chk("txrx", {tx_enable, rx_enable}, 4'h1);
    rx_request = 0;
    tx_request = 1;
    clk_alive = 0;
    wt(9900);
    chk("tx", tx_enable, 4'h1);
    wt(5200);
    chk("tx", tx_enable, 4'h0);
    clk_alive = 1;
    tx_request = 0;
    $display("test tx rx done");
  endtask
  // ------------------------------------------------------------
  // sequence and timeout
  // ------------------------------------------------------------
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      miscompares++;
      close_out;
    end
  end
  initial
  begin
    repeat (8) @(negedge clk);
    rst = 0;
    t_boot;
    t_refuse;
    t_param(4'ha, 4'hc, 1'b0);
    t_param(4'h5, 4'hf, 1'b1);
    t_param(4'h0, 4'h3, 1'b0);
    t_data(4'h6, 4'ha);
    t_srst;
    t_txrx;
    close_out;
  end
endmodule // field_slave_param_data_ports_bench
